// ### src/sec_cfg.svh
// constants for the serial eeprom command and protection block
`ifndef SEC_CFG_SVH
`define SEC_CFG_SVH
`define SEC_OP_SET_WL 8'h06
`define SEC_OP_CLR_WL 8'h04
`define SEC_OP_RD_SR 8'h05
`define SEC_OP_WR_SR 8'h01
`define SEC_OP_READ 8'h03
`define SEC_OP_WRITE 8'h02
`define SEC_SR_LOCK 7
`define SEC_SR_BGH 3
`define SEC_SR_BGL 2
`define SEC_SR_WL 1
`define SEC_SR_BUSY 0
`define SEC_SR_WMASK 8'hFC
`define SEC_QTR_BASE 13'h1800
`define SEC_HALF_BASE 13'h1000
`define SEC_WRITE_MS 3
`define SEC_CLK_MHZ 125
`endif

// ### src/sec_core.sv
// serial eeprom command decode, status register and write protection
`include "sec_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sec_core #(
    parameter int WRITE_CYCLES = `SEC_WRITE_MS * `SEC_CLK_MHZ * 1000,
    parameter int PAGE_BYTES = 32,
    parameter int ADDR_BITS = 13
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // spi pins
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic hold_n,
    input wire logic wp_n,
    output logic so,
    output logic so_oe,
    // array write port, one pulse per programmed byte
    output logic prog_we,
    output logic [ADDR_BITS-1:0] prog_addr,
    output logic [7:0] prog_data,
    output logic [7:0] status_control_register
);
    localparam int PW = $clog2(PAGE_BYTES);
    logic cs_f, sck_f, si_f, hold_f, wp_f;
    // every pin passes the three-stage filter
    sec_sync #(.INIT(1'b1)) u_cs (.ref_clk(ref_clk), .resetn(resetn), .pin(cs_n), .level(cs_f));
    sec_sync #(.INIT(1'b0)) u_sck (.ref_clk(ref_clk), .resetn(resetn), .pin(sck), .level(sck_f));
    sec_sync #(.INIT(1'b0)) u_si (.ref_clk(ref_clk), .resetn(resetn), .pin(si), .level(si_f));
    sec_sync #(.INIT(1'b1)) u_hd (.ref_clk(ref_clk), .resetn(resetn), .pin(hold_n), .level(hold_f));
    sec_sync #(.INIT(1'b1)) u_wp (.ref_clk(ref_clk), .resetn(resetn), .pin(wp_n), .level(wp_f));

    logic cs_d, sck_d;
    sec_pkg::sec_state_t state;
    logic [7:0] shreg;
    logic [4:0] bitcnt;
    logic [7:0] opcode;
    logic [15:0] addr;
    logic [7:0] page_buf [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] page_vld;
    logic [5:0] nbytes;
    logic [7:0] out_sh;
    logic lock, bg_high, bg_low, wl, busy;
    logic [31:0] wcnt;
    logic [PW-1:0] drain;
    logic draining;

    // edge detection on filtered pins
    wire cs_fall = cs_d & ~cs_f;
    wire cs_rise = ~cs_d & cs_f;
    wire active = ~cs_f & hold_f;
    wire sck_rise = active & sck_f & ~sck_d;
    wire sck_fall = active & ~sck_f & sck_d;
    wire [7:0] next_shreg = {shreg[6:0], si_f};
    wire byte_done = sck_rise & (bitcnt[2:0] == 3'h7);

    // decode of the opcode byte
    wire [7:0] op_in = next_shreg;
    wire is_set = opcode == `SEC_OP_SET_WL;
    wire is_clr = opcode == `SEC_OP_CLR_WL;
    wire is_read_status_cmd = op_in == `SEC_OP_RD_SR;
    wire is_write_status_cmd = opcode == `SEC_OP_WR_SR;
    wire is_write = opcode == `SEC_OP_WRITE;
    wire op_known = (op_in == `SEC_OP_SET_WL) | (op_in == `SEC_OP_CLR_WL) | is_read_status_cmd
                  | (op_in == `SEC_OP_WR_SR) | (op_in == `SEC_OP_READ)
                  | (op_in == `SEC_OP_WRITE);
    wire op_take = busy ? is_read_status_cmd : op_known;

    // protection evaluation
    wire hw_lock = lock & ~wp_f;
    wire [ADDR_BITS-1:0] waddr = addr[ADDR_BITS-1:0];
    wire in_guard = ({bg_high, bg_low} == 2'b11)
                  | ({bg_high, bg_low} == 2'b10 & waddr >= `SEC_HALF_BASE)
                  | ({bg_high, bg_low} == 2'b01 & waddr >= `SEC_QTR_BASE);
    wire array_ok = wl & ~in_guard;
    wire sr_ok = wl & ~hw_lock;
    wire [7:0] sr_view = {lock, 3'h0, bg_high, bg_low, wl, busy};
    wire [PW-1:0] pg_idx = addr[PW-1:0];
    wire [PW-1:0] drain_idx = PW'(drain);

    // frame state and shifter
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            cs_d <= 1'b1;
            sck_d <= 1'b0;
            state <= sec_pkg::SEC_IGN;
            shreg <= 8'h00;
            bitcnt <= 5'h00;
            opcode <= 8'h00;
            addr <= 16'h0000;
        end else begin
            cs_d <= cs_f;
            sck_d <= sck_f;
            if (cs_fall) begin
                state <= sec_pkg::SEC_OPC;
                bitcnt <= 5'h00;
            end else if (sck_rise) begin
                shreg <= next_shreg;
                bitcnt <= bitcnt + 5'h01;
                unique case (state)
                    sec_pkg::SEC_OPC: if (byte_done) begin
                        opcode <= op_in;
                        bitcnt <= 5'h00;
                        if (!op_take) state <= sec_pkg::SEC_IGN;
                        else if (op_in == `SEC_OP_WRITE || op_in == `SEC_OP_READ)
                            state <= sec_pkg::SEC_ADR;
                        else state <= sec_pkg::SEC_DAT;
                    end
                    sec_pkg::SEC_ADR: begin
                        addr <= {addr[14:0], si_f};
                        if (bitcnt == 5'h0F) begin
                            bitcnt <= 5'h00;
                            state <= is_write ? sec_pkg::SEC_DAT : sec_pkg::SEC_OUT;
                        end
                    end
                    sec_pkg::SEC_DAT: if (byte_done && is_write && nbytes != 6'h00) begin
                        addr[PW-1:0] <= pg_idx + PW'(1);
                    end
                    sec_pkg::SEC_OUT, sec_pkg::SEC_IGN: begin
                    end
                endcase
            end
        end
    end

    // page buffer loading and status fields
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            wl <= 1'b0;
            busy <= 1'b0;
            lock <= 1'b0;
            bg_high <= 1'b0;
            bg_low <= 1'b0;
            page_vld <= '0;
            nbytes <= 6'h00;
            wcnt <= 32'h0;
            draining <= 1'b0;
            drain <= '0;
        end else begin
            if (cs_fall) begin
                page_vld <= '0;
                nbytes <= 6'h00;
            end
            if (sck_rise && state == sec_pkg::SEC_DAT && byte_done && is_write) begin
                page_buf[nbytes == 6'h00 ? pg_idx : pg_idx + PW'(1)] <= next_shreg;
                page_vld[nbytes == 6'h00 ? pg_idx : pg_idx + PW'(1)] <= 1'b1;
                if (nbytes != 6'h3F) nbytes <= nbytes + 6'h01;
            end
            if (cs_rise && state == sec_pkg::SEC_DAT) begin
                if (is_clr && bitcnt == 5'h00) wl <= 1'b0;
                if (is_set && bitcnt == 5'h00) wl <= 1'b1;
                if (is_write_status_cmd && bitcnt == 5'h08 && sr_ok) begin
                    lock <= shreg[`SEC_SR_LOCK];
                    bg_high <= shreg[`SEC_SR_BGH];
                    bg_low <= shreg[`SEC_SR_BGL];
                    busy <= 1'b1;
                    wcnt <= 32'h0;
                end
                // frame must end on a byte boundary; the bit count wraps every four bytes
                if (is_write && bitcnt[2:0] == 3'h0 && nbytes != 6'h00 && array_ok) begin
                    busy <= 1'b1;
                    draining <= 1'b1;
                    drain <= '0;
                    wcnt <= 32'h0;
                end
            end
            if (draining) begin
                drain <= drain + PW'(1);
                if (drain == PW'(PAGE_BYTES - 1)) draining <= 1'b0;
            end
            if (busy) begin
                wcnt <= wcnt + 32'h1;
                if (wcnt == 32'(WRITE_CYCLES - 1)) begin
                    busy <= 1'b0;
                    wl <= 1'b0;
                end
            end
        end
    end

    // serial output and array programming port
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            so <= 1'b0;
            so_oe <= 1'b0;
            out_sh <= 8'h00;
            prog_we <= 1'b0;
            prog_addr <= '0;
            prog_data <= 8'h00;
            status_control_register <= 8'h00;
        end else begin
            status_control_register <= sr_view;
            prog_we <= draining & page_vld[drain_idx];
            prog_addr <= {waddr[ADDR_BITS-1:PW], drain_idx};
            prog_data <= page_buf[drain_idx];
            if (sck_rise && state == sec_pkg::SEC_OPC && byte_done && is_read_status_cmd && op_take) begin
                out_sh <= sr_view;
            end else if (sck_fall && state == sec_pkg::SEC_DAT && opcode == `SEC_OP_RD_SR) begin
                so <= out_sh[7];
                so_oe <= 1'b1;
                out_sh <= {out_sh[6:0], out_sh[7]};
            end
            if (cs_f || !hold_f) so_oe <= 1'b0;
        end
    end
endmodule : sec_core
`default_nettype wire

// ### src/sec_pkg.sv
// types for the serial eeprom command and protection block
package sec_pkg;
    typedef enum logic [2:0] {
        SEC_OPC = 3'h0,
        SEC_ADR = 3'h1,
        SEC_DAT = 3'h3,
        SEC_OUT = 3'h2,
        SEC_IGN = 3'h6
    } sec_state_t;
endpackage : sec_pkg

// ### src/sec_sync.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sec_sync #(
    parameter logic INIT = 1'b1
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // pin and filtered level
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;
    // level only moves once the last two stages agree
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            s1 <= INIT;
            s2 <= INIT;
            s3 <= INIT;
            level <= INIT;
        end else begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                level <= s3;
            end
        end
    end
endmodule : sec_sync
`default_nettype wire

// ### testbench/sec_core_props.sv
// checker for the serial eeprom command and protection block
`timescale 1ns/1ps
`default_nettype none
module sec_core_props #(
    parameter int ADDR_BITS = 13
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic resetn,
    // spi pins
    input wire logic cs_n,
    input wire logic wp_n,
    input wire logic so_oe,
    // programming port and status view
    input wire logic prog_we,
    input wire logic [ADDR_BITS-1:0] prog_addr,
    input wire logic [7:0] status_control_register
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    wire logic [7:0] sr = status_control_register;
    // output release, status layout and programming against protection
    a_oe_desel_off: assert property (cs_n [*8] |-> !so_oe)
        else $error("output driven while deselected");
    a_zero_bits: assert property (sr[6:4] == 3'h0)
        else $error("status bits 6 to 4 not zero");
    a_full_guard: assert property (prog_we |-> sr[3:2] != 2'b11)
        else $error("program under full guard");
    a_quarter_guard: assert property (prog_we && sr[3:2] == 2'b01 |-> prog_addr < 13'h1800)
        else $error("program into guarded quarter");
    a_half_guard: assert property (prog_we && sr[3:2] == 2'b10 |-> prog_addr < 13'h1000)
        else $error("program into guarded half");
    a_prog_when_busy: assert property (prog_we |-> sr[1:0] == 2'b11)
        else $error("program without busy and latch");
    a_busy_after_cs: assert property ($rose(sr[0]) |-> cs_n)
        else $error("busy rose while selected");
    a_latch_ends: assert property ($fell(sr[0]) |-> ##[0:2] !sr[1])
        else $error("latch kept after write cycle");
endmodule : sec_core_props
bind sec_core sec_core_props #(.ADDR_BITS(ADDR_BITS)) u_props (.ref_clk(ref_clk),
    .resetn(resetn), .cs_n(cs_n), .wp_n(wp_n), .so_oe(so_oe), .prog_we(prog_we),
    .prog_addr(prog_addr), .status_control_register(status_control_register));
`default_nettype wire

// ### testbench/sec_host.sv
// spi host model driving the serial eeprom pins
`timescale 1ns/1ps
`default_nettype none
module sec_host (
    // link pins
    output logic cs_n,
    output logic sck,
    output logic si,
    // device answer
    input wire logic so
);
    logic cpol = 1'b0; // idle clock level picks mode 0,0 or 1,1
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
    end
    // select, with the clock parked at its idle level
    task automatic start();
        sck = cpol;
        #80 cs_n = 1'b0;
        #80;
    endtask : start
    // one byte each way, msb first, data set low and taken on rise
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i];
            #80 sck = 1'b1;
            rx[i] = so;
            #80;
        end
        sck = cpol;
    endtask : xfer
    // deselect; released data line shows the inverse of its last bit
    task automatic stop();
        #80 cs_n = 1'b1;
        si = ~si;
        #400;
    endtask : stop
endmodule : sec_host
`default_nettype wire

// ### testbench/test_spi_eeprom_command_protect.sv
// self-checking bench for the serial eeprom command and protection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin fail_count++; \
    $display("FAIL %s exp %h got %h", n, e, a); end end
module test_spi_eeprom_command_protect;
    logic ref_clk = 1'b0, resetn = 1'b0, hold_n = 1'b1, wp_n = 1'b1;
    logic cs_n, sck, si, so, so_oe, prog_we;
    logic [12:0] prog_addr;
    logic [7:0] prog_data, sr, rx;
    logic [7:0] pm [logic [12:0]];
    int fail_count = 0, num_checks = 0;
    always #4 ref_clk = ~ref_clk;
    sec_host u_host (.cs_n(cs_n), .sck(sck), .si(si), .so(so));
    sec_core #(.WRITE_CYCLES(2000)) u_dut (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n),
        .sck(sck), .si(si), .hold_n(hold_n), .wp_n(wp_n), .so(so), .so_oe(so_oe),
        .prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data),
        .status_control_register(sr));
    // record every programmed byte
    always @(posedge ref_clk) if (prog_we === 1'b1) pm[prog_addr] = prog_data;
    task automatic frame(input logic [7:0] a, b = 8'h00, int n = 1);
        u_host.start();
        u_host.xfer(a, rx);
        if (n > 1) u_host.xfer(b, rx);
        u_host.stop();
    endtask : frame
    task automatic wait_idle();
        for (int i = 0; i < 3000 && sr[0] !== 1'b0; i++) @(posedge ref_clk);
        #1;
    endtask : wait_idle
    // latch set, clear and refused opcodes
    task automatic t_latch();
        `CHK("sr_reset", 8'h00, sr)
        frame(8'h06);
        `CHK("sr_set", 8'h02, sr)
        frame(8'hFF);
        `CHK("sr_unknown", 8'h02, sr)
        frame(8'h04);
        `CHK("sr_clear", 8'h00, sr)
        frame(8'h01, 8'h8C, 2);
        `CHK("sr_no_latch", 8'h00, sr)
        $display("test latch done");
    endtask : t_latch
    // status write, lock pin and status read over the link
    task automatic t_status();
        frame(8'h06);
        frame(8'h01, 8'hFF, 2);
        `CHK("sr_busy", 8'h03, sr & 8'h03)
        wait_idle();
        `CHK("sr_written", 8'h8C, sr)
        u_host.start();
        u_host.xfer(8'h05, rx);
        u_host.xfer(8'h00, rx);
        u_host.stop();
        `CHK("sr_read", 8'h8C, rx)
        wp_n = 1'b0;
        frame(8'h06);
        frame(8'h01, 8'h00, 2);
        `CHK("sr_locked", 8'h8E, sr)
        wp_n = 1'b1;
        frame(8'h01, 8'h04, 2);
        wait_idle();
        `CHK("sr_unlocked", 8'h04, sr)
        $display("test status done");
    endtask : t_status
    // page write with wrap in mode 1,1, busy lockout, guarded quarter
    task automatic t_page();
        u_host.cpol = 1'b1;
        pm.delete();
        frame(8'h06);
        u_host.start();
        u_host.xfer(8'h02, rx);
        u_host.xfer(8'hE7, rx);
        u_host.xfer(8'hFE, rx);
        u_host.xfer(8'hA1, rx);
        u_host.xfer(8'hB2, rx);
        u_host.xfer(8'hC3, rx);
        u_host.stop();
        `CHK("busy_at_cs", 1'b1, sr[0])
        frame(8'h06);
        wait_idle();
        `CHK("sr_after_page", 8'h04, sr)
        `CHK("pm_count", 3, pm.num())
        `CHK("pm_7fe", 8'hA1, pm[13'h07FE])
        `CHK("pm_7ff", 8'hB2, pm[13'h07FF])
        `CHK("pm_7e0", 8'hC3, pm[13'h07E0])
        pm.delete();
        frame(8'h06);
        u_host.start();
        u_host.xfer(8'h02, rx);
        u_host.xfer(8'h18, rx);
        u_host.xfer(8'h00, rx);
        u_host.xfer(8'h55, rx);
        u_host.stop();
        #2000;
        `CHK("pm_guarded", 0, pm.num())
        `CHK("sr_guarded", 8'h06, sr)
        $display("test page done");
    endtask : t_page
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    initial begin
        repeat (2) @(posedge ref_clk);
        #1 resetn = 1'b1;
        #200;
        t_latch();
        t_status();
        t_page();
        complete_run();
    end
    initial begin
        #600000;
        fail_count++;
        complete_run();
    end
endmodule : test_spi_eeprom_command_protect
`default_nettype wire
